// ===== logic/lpa_capture.sv
// partner ability register bank with apb slave and next page view
//
// What this block does
// - read-only 16-bit partner ability word at index 0x05 on the bus
// - after successful negotiation with next pages enabled, next page replaces base view
// - base view bit 15 shows partner next page request, resets 0
// - bit 14 shows partner acknowledge, set only from received words, resets 0
// - bit 13 shows partner remote fault, resets 0
// - bit 12 of base view always reads 0, writes ignored
// - bit 11 shows partner asymmetric pause, resets 0
// - bit 10 shows partner symmetric pause, resets 0
// - bits 9..5 show partner technology abilities, reset 0
// - bits 4..0 hold partner selector as received, reset 0
// - next page view bits 13,12,11: message flag, comply flag, toggle
// - next page view bits 10..0 carry received page code
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module lpa_capture
    import lpa_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_W
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // negotiation engine
    input  wire lcw_t                rx_lcw,
    input  wire logic                an_complete,
    // decoded partner abilities
    output base_fields_t             base_fields,
    output next_fields_t             next_fields,
    output logic                     view_is_next
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (CNT_WIDTH < 1 || CNT_WIDTH > 16) begin : g_bad_cnt
        $error("lpa_capture: page counter width must be 1 to 16");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [15:0]          base_word;
    logic [15:0]          next_word;
    logic                 load_base;
    logic                 load_next;
    logic                 page_enable_ff;
    logic                 view_next_ff;
    logic                 base_seen_ff;
    logic                 next_seen_ff;
    logic [CNT_WIDTH-1:0] page_cnt_ff;
    logic [31:0]          prdata_ff;
    logic                 pslverr_ff;
    logic [31:0]          nxt_prdata;
    logic                 nxt_pslverr;
    logic                 setup_phase;
    logic                 access_phase;
    logic                 wr_ctrl;
    logic                 clr_seen;
    logic [15:0]          view_word;
    logic [7:0]           idx;
    logic                 addr_aligned;

    // ****************************************************************
    // capture decisions
    // ****************************************************************
    // before completion every validated word is the partner base page
    assign load_base = rx_lcw.valid && !an_complete;
    // after completion words are next pages, but only if software allows
    assign load_next = rx_lcw.valid && an_complete && page_enable_ff;

    // base page holder, reserved bit forced low on the way in
    lpa_word_hold #(
        .W    (WORD_W),
        .MASK (BASE_MASK)
    ) u_base_hold (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (load_base),
        .din     (rx_lcw.word),
        .dout    (base_word)
    );

    // next page holder, every bit carries partner data
    lpa_word_hold #(
        .W    (WORD_W),
        .MASK (NEXT_MASK)
    ) u_next_hold (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (load_next),
        .din     (rx_lcw.word),
        .dout    (next_word)
    );

    // ****************************************************************
    // view selection
    // ****************************************************************
    // falls back to base when negotiation restarts, so a stale next page
    // never masks a fresh base page
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            view_next_ff <= 1'b0;
        end else if (!an_complete) begin
            view_next_ff <= 1'b0;
        end else if (load_next) begin
            view_next_ff <= 1'b1;
        end
    end

    assign view_word    = view_next_ff ? next_word : base_word;
    assign view_is_next = view_next_ff;

    // ****************************************************************
    // decoded field outputs
    // ****************************************************************
    // straight casts of the holders; the flops live in the holders
    assign base_fields = base_fields_t'(base_word);
    assign next_fields = next_fields_t'(next_word);

    // ****************************************************************
    // control register
    // ****************************************************************
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign idx          = paddr[ADDR_W-1:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign wr_ctrl      = access_phase && pwrite && addr_aligned
                          && (idx == IDX_CTRL) && pstrb[0];
    // clear request is a one-cycle pulse, never stored
    assign clr_seen     = wr_ctrl && pwdata[CTRL_CLR_SEEN];

    // next page enable, written through byte lane 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_enable_ff <= PAGE_EN_RST;
        end else if (wr_ctrl) begin
            page_enable_ff <= pwdata[CTRL_PAGE_EN];
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // a page arriving in the clear cycle wins, so no arrival is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_seen_ff <= 1'b0;
        end else if (load_base) begin
            base_seen_ff <= 1'b1;
        end else if (clr_seen) begin
            base_seen_ff <= 1'b0;
        end
    end

    // same policy for next pages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_seen_ff <= 1'b0;
        end else if (load_next) begin
            next_seen_ff <= 1'b1;
        end else if (clr_seen) begin
            next_seen_ff <= 1'b0;
        end
    end

    // saturating next page counter; restarts with each negotiation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_cnt_ff <= '0;
        end else if (load_base) begin
            page_cnt_ff <= '0;
        end else if (load_next && !(&page_cnt_ff)) begin
            page_cnt_ff <= page_cnt_ff + 1'b1;
        end
    end

    // ****************************************************************
    // read mux and error decode
    // ****************************************************************
    // sampled in setup so prdata comes from a flop with zero wait states
    always_comb begin
        nxt_prdata  = BUS_ZERO;
        nxt_pslverr = 1'b0;
        if (!addr_aligned) begin
            nxt_pslverr = 1'b1;
        end else begin
            case (idx)
                IDX_PARTNER_WORD: begin
                    nxt_prdata[15:0] = view_word;
                end
                IDX_CTRL: begin
                    nxt_prdata[CTRL_PAGE_EN] = page_enable_ff;
                end
                IDX_STATUS: begin
                    nxt_prdata[0]              = view_next_ff;
                    nxt_prdata[1]              = base_seen_ff;
                    nxt_prdata[2]              = next_seen_ff;
                    nxt_prdata[3]              = an_complete;
                    nxt_prdata[8 +: CNT_WIDTH] = page_cnt_ff;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // read data latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= BUS_ZERO;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? BUS_ZERO : nxt_prdata;
        end
    end

    // error latch; writes to the read-only word are quietly dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && access_phase;
    assign pready  = 1'b1;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_base_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        base_word[BIT_RSVD] == 1'b0;
    endproperty
    a_base_rsvd_zero: assert property (p_base_rsvd_zero)
        else $error("reserved base bit not zero");

    property p_base_capture;
        @(posedge pclk) disable iff (!presetn)
        (rx_lcw.valid && !an_complete) |=> (base_word == ($past(rx_lcw.word) & BASE_MASK));
    endproperty
    a_base_capture: assert property (p_base_capture)
        else $error("base word not captured whole");

    property p_next_capture;
        @(posedge pclk) disable iff (!presetn)
        (rx_lcw.valid && an_complete && page_enable_ff)
            |=> (next_word == $past(rx_lcw.word)) && view_next_ff;
    endproperty
    a_next_capture: assert property (p_next_capture)
        else $error("next page not captured or view not switched");

    property p_no_page_when_off;
        @(posedge pclk) disable iff (!presetn)
        (!page_enable_ff && !view_next_ff) |=> !view_next_ff;
    endproperty
    a_no_page_when_off: assert property (p_no_page_when_off)
        else $error("next page view without enable");

    property p_base_hold;
        @(posedge pclk) disable iff (!presetn)
        !(rx_lcw.valid && !an_complete) |=> $stable(base_word);
    endproperty
    a_base_hold: assert property (p_base_hold)
        else $error("base word changed without a valid word");

    property p_next_hold;
        @(posedge pclk) disable iff (!presetn)
        !(rx_lcw.valid && an_complete) |=> $stable(next_word);
    endproperty
    a_next_hold: assert property (p_next_hold)
        else $error("next page word changed without a valid word");

    property p_read_word;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == {IDX_PARTNER_WORD, 2'b00})
            ##1 access_phase
            |-> prdata == {16'h0000, $past(view_word)} && !pslverr;
    endproperty
    a_read_word: assert property (p_read_word)
        else $error("partner word read returned wrong data");

    property p_view_base_idle;
        @(posedge pclk) disable iff (!presetn)
        !an_complete |=> !view_next_ff;
    endproperty
    a_view_base_idle: assert property (p_view_base_idle)
        else $error("next page view while negotiating");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr[1:0] == 2'b00 && idx != IDX_PARTNER_WORD
            && idx != IDX_CTRL && idx != IDX_STATUS) ##1 access_phase |-> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not flagged");

    // refused next pages must leave both the word and the view untouched
    property p_next_refused;
        @(posedge pclk) disable iff (!presetn)
        (rx_lcw.valid && an_complete && !page_enable_ff)
            |=> $stable(next_word) && $stable(view_next_ff);
    endproperty
    a_next_refused: assert property (p_next_refused)
        else $error("next page taken while disabled");

    // acknowledge only ever moves with a received base word
    property p_ack_from_word;
        @(posedge pclk) disable iff (!presetn)
        $changed(base_word[BIT_ACK]) |-> $past(load_base);
    endproperty
    a_ack_from_word: assert property (p_ack_from_word)
        else $error("acknowledge bit changed without a received word");

    property p_misaligned_err;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr[1:0] != 2'b00) ##1 access_phase
            |-> pslverr && prdata == BUS_ZERO;
    endproperty
    a_misaligned_err: assert property (p_misaligned_err)
        else $error("misaligned access not refused");

    property p_rsvd_read_zero;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && !view_next_ff && idx == IDX_PARTNER_WORD)
            ##1 access_phase |-> prdata[BIT_RSVD] == 1'b0;
    endproperty
    a_rsvd_read_zero: assert property (p_rsvd_read_zero)
        else $error("reserved bit read back as one");

endmodule // lpa_capture

// ===== logic/lpa_pkg.sv
// shared constants and carriers for the partner ability capture block
package lpa_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0]  IDX_PARTNER_WORD = 8'h05;
    localparam logic [7:0]  IDX_CTRL         = 8'h10;
    localparam logic [7:0]  IDX_STATUS       = 8'h11;
    localparam int          ADDR_W           = 10;
    localparam int          WORD_W           = 16;

    // ****************************************************************
    // field positions, base view
    // ****************************************************************
    localparam int BIT_FURTHER_PAGE = 15;
    localparam int BIT_ACK          = 14;
    localparam int BIT_FAULT        = 13;
    localparam int BIT_RSVD         = 12;
    localparam int BIT_ASYM         = 11;
    localparam int BIT_PAUSE        = 10;
    localparam int SEL_MSB          = 4;

    // ****************************************************************
    // field positions, next page view
    // ****************************************************************
    localparam int BIT_MSG_PAGE     = 13;
    localparam int BIT_COMPLY       = 12;
    localparam int BIT_TOGGLE       = 11;
    localparam int CODE_MSB         = 10;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [15:0] WORD_RST       = 16'h0000;
    localparam logic [15:0] BASE_MASK      = 16'hefff;
    localparam logic [15:0] NEXT_MASK      = 16'hffff;
    localparam logic        PAGE_EN_RST    = 1'b1;
    localparam int          CTRL_PAGE_EN   = 0;
    localparam int          CTRL_CLR_SEEN  = 1;
    localparam int          CNT_W          = 8;
    localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;

    // one complete, validated link code word from the negotiation engine
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } lcw_t;

    // decoded base page of the partner
    typedef struct packed {
        logic       further_page_request;
        logic       acknowledge;
        logic       partner_fault_flag;
        logic       reserved;
        logic       asymmetric_flow_control;
        logic       pause;
        logic       four_pair_100_ability;
        logic       fast_full_duplex_ability;
        logic       fast_half_duplex_ability;
        logic       slow_full_duplex_ability;
        logic       slow_half_duplex_ability;
        logic [4:0] selector;
    } base_fields_t;

    // decoded next page of the partner
    typedef struct packed {
        logic        further_page_request;
        logic        acknowledge;
        logic        message_page_flag;
        logic        comply_ability_flag;
        logic        toggle;
        logic [10:0] code;
    } next_fields_t;

endpackage

// ===== logic/lpa_word_hold.sv
// whole-word capture register with a fixed read-as-zero mask
`timescale 1ns/1ps
module lpa_word_hold
    import lpa_pkg::*;
#(
    parameter int          W    = 16,
    parameter logic [15:0] MASK = 16'hffff
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // capture side
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    // held word
    output logic [W-1:0]      dout
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (W != WORD_W) begin : g_bad_width
        $error("lpa_word_hold: width must equal the link code word");
    end

    // ****************************************************************
    // capture
    // ****************************************************************
    // all bits load on one edge so a reader never sees a mixed word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= WORD_RST[W-1:0];
        end else if (load) begin
            dout <= din & MASK[W-1:0];
        end
    end

endmodule // lpa_word_hold

// ===== bench/lpa_partner.sv
// link partner model that hands validated link code words to the capture block
`timescale 1ns/1ps
module lpa_partner
    import lpa_pkg::*;
(
    // clock
    input  wire logic pclk,
    // negotiation side
    output lcw_t      rx_lcw,
    output logic      an_complete
);
    // ****************************************************************
    // idle values
    // ****************************************************************
    // word bus is never left showing the last word unless keep chains it, so a stray load shows up
    initial begin
        rx_lcw      = '0;
        an_complete = 1'b0;
    end

    // one whole word per pulse; gap makes the partner slow, keep chains words
    task automatic send(input logic [15:0] w, input int gap, input logic keep);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        rx_lcw <= '{valid: 1'b1, word: w};
        if (!keep) begin
            @(posedge pclk);
            rx_lcw <= '{valid: 1'b0, word: ~w};
        end
    endtask

    // negotiation finished flag, a level
    task automatic set_done(input logic d);
        @(posedge pclk);
        an_complete <= d;
    endtask
endmodule // lpa_partner

// ===== bench/test_link_partner_ability_capture.sv
// self-checking bench for the partner ability register bank
`timescale 1ns/1ps
module test_link_partner_ability_capture;
    import lpa_pkg::*;

    // ****************************************************************
    // signals and model state
    // ****************************************************************
    localparam logic [9:0] A_WORD = {IDX_PARTNER_WORD, 2'b00};
    localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] A_STAT = {IDX_STATUS, 2'b00};
    localparam logic [9:0] A_BAD  = 10'h3fc;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, view_is_next;
    logic [9:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [3:0]         pstrb;
    lcw_t               rx_lcw;
    logic               an_complete, err;
    base_fields_t       base_fields;
    next_fields_t       next_fields;
    logic [15:0]        m_base, m_next, seed, w;
    logic               m_view, m_pg_en;
    int                 error_cnt, samples_checked;

    // ****************************************************************
    // design and partner
    // ****************************************************************
    lpa_capture dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_lcw(rx_lcw), .an_complete(an_complete),
        .base_fields(base_fields), .next_fields(next_fields), .view_is_next(view_is_next));
    lpa_partner partner_u (.pclk(pclk), .rx_lcw(rx_lcw), .an_complete(an_complete));

    // clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            results();
        end
    endtask

    // model: base loads while negotiating, next page only after success
    task automatic push(input logic [15:0] v, input int gap, input logic keep);
        partner_u.send(v, gap, keep);
        if (!an_complete) m_base = v & 16'hefff;
        else if (m_pg_en) begin
            m_next = v;
            m_view = 1'b1;
        end
    endtask

    task automatic m_rst();
        m_base = '0;
        m_next = '0;
        m_view = 1'b0;
        m_pg_en = 1'b1;
    endtask

    task automatic check_all();
        apb(1'b0, A_WORD, 32'h0000_0000);
        @(negedge pclk);
        chk("word", {16'h0000, m_view ? m_next : m_base}, rd);
        chk("word_err", 32'h0000_0000, {31'h0, err});
        chk("base", {16'h0000, m_base}, {16'h0000, base_fields});
        chk("next", {16'h0000, m_next}, {16'h0000, next_fields});
        chk("view", {31'h0, m_view}, {31'h0, view_is_next});
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {presetn, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        seed = 16'h000b;
        m_rst();
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        apb(1'b0, A_CTRL, 32'h0000_0000);
        chk("ctrl_rst", 32'h0000_0001, rd);
        // walking ones pin every field position, then random words
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            w = (i < 16) ? (16'h0001 << i) : seed;
            push(w, i % 3, 1'b0);
            check_all();
        end
        // the word is read-only; a write leaves it alone and raises no error
        apb(1'b1, A_WORD, 32'h0000_ffff);
        chk("wr_err", 32'h0000_0000, {31'h0, err});
        check_all();
        apb(1'b0, A_BAD, 32'h0000_0000);
        chk("bad_err", 32'h0000_0001, {31'h0, err});
        chk("bad_rd", 32'h0000_0000, rd);
        apb(1'b0, A_WORD | 10'h002, 32'h0000_0000);
        chk("mis_err", 32'h0000_0001, {31'h0, err});
        // status: base pages seen, then cleared by the write-one pulse
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk("stat_base", 32'h0000_0002, rd);
        apb(1'b1, A_CTRL, 32'h0000_0003);
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk("stat_clr", 32'h0000_0000, rd);
        // successful negotiation: next pages replace the base view
        partner_u.set_done(1'b1);
        check_all();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            w = (i == 0) ? 16'hffff : seed;
            push(w, i, 1'b0);
            check_all();
        end
        // eight next pages counted, view on next, base flag still clear
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk("stat_next", 32'h0000_080d, rd);
        // back-to-back words: only the last whole word remains
        push(16'h1234, 0, 1'b1);
        push(16'hbeef, 0, 1'b0);
        check_all();
        // next pages refused while disabled
        apb(1'b1, A_CTRL, 32'h0000_0000);
        m_pg_en = 1'b0;
        push(16'h5a5a, 1, 1'b0);
        check_all();
        apb(1'b1, A_CTRL, 32'h0000_0001);
        m_pg_en = 1'b1;
        // negotiation restarts: base view returns
        partner_u.set_done(1'b0);
        m_view = 1'b0;
        repeat (2) @(posedge pclk);
        check_all();
        push(16'hc3a1, 0, 1'b0);
        check_all();
        // reset in mid-run clears every field
        @(posedge pclk);
        presetn <= 1'b0;
        m_rst();
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        results();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        results();
    end
endmodule // test_link_partner_ability_capture
